// [logic/udf_defs.svh]
`ifndef UDF_DEFS_SVH
`define UDF_DEFS_SVH
`define UDF_OFS_MCAST        12'h324
`define UDF_OFS_VLAN         12'h328
`define UDF_OFS_MACCTL       12'h330
`define UDF_OFS_FRAME        12'h340
`define UDF_OFS_STATUS       12'h344
`define UDF_POL_EN_BIT       31
`define UDF_POL_PORTS_W      3
`define UDF_CTL_ALT_BO_BIT   7
`define UDF_CTL_LEN_CHK_BIT  3
`define UDF_CTL_FC_MODE_BIT  1
`define UDF_CTL_AGGR_BO_BIT  0
`define UDF_MACCTL_RESET     8'h0E
`define UDF_FC_ETYPE         16'h8808
`define UDF_FC_DA            48'h0180C2000001
`define UDF_LEN_LIMIT        16'h05DC
`endif

// [logic/udf_pkg.sv]
package udf_pkg;
   typedef struct packed {
      logic       fwd_en;
      logic [2:0] ports;
   } udf_policy_type;
   typedef enum logic [1:0] {UDF_NONE, UDF_VLAN, UDF_UCAST, UDF_MCAST} udf_cat_type;
endpackage

// [logic/udf_ctrl.sv]
// Overview of operation
// [R1] multicast forward enable bit 31 gates forwarding
// [R2] multicast select bits 2..0 pick ports 3..1
// [R3] vlan forward enable bit 31 gates forwarding
// [R4] vlan select bits 2..0 pick ports 3..1
// [R5] alternate back-off bit 7, half duplex only
// [R6] software sets bit 7 with no-excess-collision drop
// [R7] length check bit 3 discards mismatched short frames
// [R8] drop mode set: drop on type or address
// [R9] drop mode clear: drop on type and address
// [R10] aggressive back-off bit 0, default off
// [R11] precedence: vlan, unicast, multicast
// [R12] policy bits 30..3 read zero, ignore writes
`timescale 1ns/1ps
`include "udf_defs.svh"
module udf_ctrl
(
   input  wire logic        clk,            // 20 MHz core clock
   input  wire logic        rst_n,          // sync reset, low
   input  wire logic        wb_cyc_i,       // wishbone cycle
   input  wire logic        wb_stb_i,       // wishbone strobe
   input  wire logic        wb_we_i,        // write enable
   input  wire logic [11:0] wb_adr_i,       // byte address
   input  wire logic [3:0]  wb_sel_i,       // byte lanes
   input  wire logic [31:0] wb_dat_i,       // write data
   output logic      [31:0] wb_dat_o,       // read data
   output logic             wb_ack_o,       // acknowledge
   input  wire logic        half_duplex,    // port in half duplex
   input  wire logic        uc_unknown,     // unknown unicast seen
   input  wire logic [2:0]  uc_ports,       // unicast policy ports
   input  wire logic        uc_fwd_en,      // unicast policy enable
   output logic      [2:0]  fwd_ports,      // flood ports 3..1
   output logic             fwd_valid,      // a policy applied
   output logic             alt_backoff,    // alternate back-off active
   output logic             aggr_backoff,   // aggressive back-off active
   output logic             frame_drop      // evaluated frame is dropped
);

   //////////////////////////////////////////////////////////////////////////////
   udf_pkg::udf_policy_type mcast;
   udf_pkg::udf_policy_type next_mcast;
   udf_pkg::udf_policy_type vlan;
   udf_pkg::udf_policy_type next_vlan;
   logic [7:0]              macctl;
   logic [7:0]              next_macctl;
   logic [31:0]             frame;          // [31]mc [30]vid [15:0]type/len
   logic [31:0]             next_frame;
   logic [15:0]             frame_len;
   logic [15:0]             next_frame_len;
   logic [47:0]             frame_da;
   logic [47:0]             next_frame_da;
   logic                    next_ack;
   logic [31:0]             next_rdata;
   logic [2:0]              next_fwd_ports;
   logic                    next_fwd_valid;
   logic                    next_drop;
   logic                    wr;
   logic                    is_type;
   logic                    is_da;
   logic                    len_bad;
   udf_pkg::udf_cat_type    cat;

   // write lands on the edge where the master samples ack high, never earlier
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

   //////////////////////////////////////////////////////////////////////////////
   // register file; frame descriptor registers let software drive the classifier
   always_comb
   begin
      next_mcast     = mcast;
      next_vlan      = vlan;
      next_macctl    = macctl;
      next_frame     = frame;
      next_frame_len = frame_len;
      next_frame_da  = frame_da;
      next_ack       = wb_cyc_i && wb_stb_i && !wb_ack_o;
      next_rdata     = 32'h00000000;
      if (wr)
      begin
         unique case (wb_adr_i)
            `UDF_OFS_MCAST:
            begin
               if (wb_sel_i[3]) next_mcast.fwd_en = wb_dat_i[`UDF_POL_EN_BIT]; // R1
               if (wb_sel_i[0]) next_mcast.ports = wb_dat_i[2:0];              // R2 R12
            end
            `UDF_OFS_VLAN:
            begin
               if (wb_sel_i[3]) next_vlan.fwd_en = wb_dat_i[`UDF_POL_EN_BIT];  // R3
               if (wb_sel_i[0]) next_vlan.ports = wb_dat_i[2:0];               // R4 R12
            end
            `UDF_OFS_MACCTL:
               if (wb_sel_i[0]) next_macctl = wb_dat_i[7:0];
            `UDF_OFS_FRAME:
            begin
               if (wb_sel_i[0]) next_frame[7:0] = wb_dat_i[7:0];
               if (wb_sel_i[1]) next_frame[15:8] = wb_dat_i[15:8];
               if (wb_sel_i[2]) next_frame_len = wb_dat_i[31:16];
               if (wb_sel_i[3]) next_frame[31:30] = wb_dat_i[31:30];
            end
            `UDF_OFS_STATUS:
               if (wb_sel_i[0]) next_frame_da = {wb_dat_i[15:0], frame_da[47:16]};
            default:
               next_frame = frame;
         endcase
      end
      unique case (wb_adr_i)
         `UDF_OFS_MCAST:  next_rdata = {mcast.fwd_en, 28'h0000000, mcast.ports}; // R12
         `UDF_OFS_VLAN:   next_rdata = {vlan.fwd_en, 28'h0000000, vlan.ports};   // R12
         `UDF_OFS_MACCTL: next_rdata = {24'h000000, macctl};
         `UDF_OFS_FRAME:  next_rdata = {frame_len, frame[15:0]} | {frame[31:30], 30'h00000000};
         `UDF_OFS_STATUS: next_rdata = {25'h0, frame_drop, fwd_valid, aggr_backoff,
                                        alt_backoff, fwd_ports};
         default:         next_rdata = 32'h00000000;
      endcase
   end

   //////////////////////////////////////////////////////////////////////////////
   // classification and drop decision
   assign is_type = frame[15:0] == `UDF_FC_ETYPE;
   assign is_da   = frame_da == `UDF_FC_DA;
   assign len_bad = frame[15:0] < `UDF_LEN_LIMIT && frame_len != frame[15:0];

   always_comb
   begin
      if (frame[30])
         cat = udf_pkg::UDF_VLAN;                                              // R11
      else if (uc_unknown)
         cat = udf_pkg::UDF_UCAST;                                             // R11
      else if (frame[31])
         cat = udf_pkg::UDF_MCAST;
      else
         cat = udf_pkg::UDF_NONE;
      next_fwd_ports = 3'h0;
      next_fwd_valid = 1'b0;
      unique case (cat)
         udf_pkg::UDF_VLAN:
         begin
            next_fwd_valid = vlan.fwd_en;                                      // R3
            next_fwd_ports = vlan.fwd_en ? vlan.ports : 3'h0;                  // R4
         end
         udf_pkg::UDF_UCAST:
         begin
            next_fwd_valid = uc_fwd_en;
            next_fwd_ports = uc_fwd_en ? uc_ports : 3'h0;
         end
         udf_pkg::UDF_MCAST:
         begin
            next_fwd_valid = mcast.fwd_en;                                     // R1
            next_fwd_ports = mcast.fwd_en ? mcast.ports : 3'h0;                // R2
         end
         udf_pkg::UDF_NONE:
         begin
            next_fwd_valid = 1'b0;
            next_fwd_ports = 3'h0;
         end
      endcase
      if (macctl[`UDF_CTL_FC_MODE_BIT])
         next_drop = is_type || is_da;                                         // R8
      else
         next_drop = is_type && is_da;                                         // R9
      if (macctl[`UDF_CTL_LEN_CHK_BIT] && len_bad)
         next_drop = 1'b1;                                                     // R7
   end

   //////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         mcast        <= '0;
         vlan         <= '0;
         macctl       <= `UDF_MACCTL_RESET;                                    // R5 R7 R10
         frame        <= 32'h00000000;
         frame_len    <= 16'h0000;
         frame_da     <= 48'h000000000000;
         wb_ack_o     <= 1'b0;
         wb_dat_o     <= 32'h00000000;
         fwd_ports    <= 3'h0;
         fwd_valid    <= 1'b0;
         frame_drop   <= 1'b0;
         alt_backoff  <= 1'b0;
         aggr_backoff <= 1'b0;
      end
      else
      begin
         mcast        <= next_mcast;
         vlan         <= next_vlan;
         macctl       <= next_macctl;
         frame        <= next_frame;
         frame_len    <= next_frame_len;
         frame_da     <= next_frame_da;
         wb_ack_o     <= next_ack;
         wb_dat_o     <= next_rdata;
         fwd_ports    <= next_fwd_ports;
         fwd_valid    <= next_fwd_valid;
         frame_drop   <= next_drop;
         // back-off modes ignored in full duplex; R6 left to software
         alt_backoff  <= macctl[`UDF_CTL_ALT_BO_BIT] && half_duplex;           // R5
         aggr_backoff <= macctl[`UDF_CTL_AGGR_BO_BIT] && half_duplex;          // R10
      end
   end

endmodule

// [testbench/udf_ctrl_monitor.sv]
`timescale 1ns/1ps
module udf_ctrl_monitor
(
   input wire logic        clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i, wb_dat_o,
   input wire logic        half_duplex, uc_unknown, uc_fwd_en,
   input wire logic [2:0]  uc_ports, fwd_ports,
   input wire logic        fwd_valid, alt_backoff, aggr_backoff, frame_drop
);
   logic vid_seen;  // mirrors the stored unknown-vid flag
   always_ff @(posedge clk)
      if (!rst_n)
         vid_seen <= 1'b0;
      else if (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 12'h340 && wb_sel_i[3])
         vid_seen <= wb_dat_i[30];
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered");
   a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_alt_half: assert property (alt_backoff |-> $past(half_duplex))
      else $error("alternate back-off in full duplex");
   a_aggr_half: assert property (aggr_backoff |-> $past(half_duplex))
      else $error("aggressive back-off in full duplex");
   a_bo_reset: assert property ($rose(rst_n) |-> !alt_backoff && !aggr_backoff)
      else $error("back-off active after reset");
   a_idle_ports: assert property (!fwd_valid |-> fwd_ports == 3'h0)
      else $error("ports without forwarding");
   a_resv_zero: assert property (wb_ack_o && !$past(wb_we_i) &&
      ($past(wb_adr_i) == 12'h324 || $past(wb_adr_i) == 12'h328) |-> wb_dat_o[30:3] == 28'h0)
      else $error("policy reserved bits not zero");
   a_ucast_wins: assert property ($past(rst_n) && $past(uc_unknown) && !$past(vid_seen) |->
      fwd_valid == $past(uc_fwd_en) && fwd_ports == ($past(uc_fwd_en) ? $past(uc_ports) : 3'h0))
      else $error("unicast policy not applied");
   c_write: cover property (wb_ack_o && $past(wb_we_i));
   c_backoff: cover property (alt_backoff && aggr_backoff);
   c_drop: cover property (frame_drop);
endmodule
bind udf_ctrl udf_ctrl_monitor mon (.clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o, .wb_adr_i,
   .wb_sel_i, .wb_dat_i, .wb_dat_o, .half_duplex, .uc_unknown, .uc_fwd_en, .uc_ports, .fwd_ports,
   .fwd_valid, .alt_backoff, .aggr_backoff, .frame_drop);

// [testbench/test_udf_ctrl.sv]
`timescale 1ns/1ps
module test_udf_ctrl;
   logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, hd = 1'b0, uc = 1'b0, uc_en = 1'b0;
   logic [11:0] adr = 12'h0;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wd = 32'h0, rd_v, rdata;
   logic [2:0]  uc_p = 3'h0, fp;
   logic        ack, fv, alt, aggr, drop;
   int          n_fail = 0, samples_checked = 0;
   udf_ctrl dut (.clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wd), .wb_dat_o(rd_v), .wb_ack_o(ack), .half_duplex(hd), .uc_unknown(uc), .uc_ports(uc_p),
      .uc_fwd_en(uc_en), .fwd_ports(fp), .fwd_valid(fv), .alt_backoff(alt), .aggr_backoff(aggr),
      .frame_drop(drop));
   always #25 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wd <= d;
      sel <= 4'hF;
      do
         @(posedge clk);
      while (ack !== 1'b1);
      rdata = rd_v;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         n_fail++;
         $display("BAD %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk("reg", rdata, e);
   endtask
   task automatic settle;
      // outputs trail a register write by one edge
      repeat (3) @(posedge clk);
   endtask
   task automatic drop_case(input logic [7:0] c, input logic [15:0] t, input logic [15:0] l, input logic m,
      input logic e);
      bus(1'b1, 12'h330, {24'h0, c});
      bus(1'b1, 12'h344, 32'h0001);
      bus(1'b1, 12'h344, 32'hC200);
      bus(1'b1, 12'h344, m ? 32'h0180 : 32'h0181);
      bus(1'b1, 12'h340, {l, t});
      settle;
      chk("drop", {31'h0, drop}, {31'h0, e});
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      stop_test;
   end
   initial
   begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rdchk(12'h324, 32'h0);
      rdchk(12'h328, 32'h0);
      rdchk(12'h330, 32'hE);
      $display("reset values done");
      for (int p = 0; p < 8; p++)
      begin
         bus(1'b1, 12'h324, 32'hFFFFFFF8 | p);
         bus(1'b1, 12'h328, 32'h7FFFFFF8 | (7 - p));
         rdchk(12'h324, 32'h80000000 | p);
         rdchk(12'h328, 32'h7 - p);
         bus(1'b1, 12'h340, 32'h80000600);
         settle;
         chk("mcast", {fv, fp}, 8 | p);
         bus(1'b1, 12'h340, 32'hC0000600);
         settle;
         chk("vid off", {fv, fp}, 0);
         bus(1'b1, 12'h328, 32'h80000000 | (7 - p));
         settle;
         chk("vid on", {fv, fp}, 8 | (7 - p));
         uc <= 1'b1;
         uc_en <= p[0];
         uc_p <= ~p[2:0];
         bus(1'b1, 12'h340, 32'h80000600);
         settle;
         chk("ucast", {fv, fp}, p[0] ? 8 | (7 - p) : 0);
         uc <= 1'b0;
         bus(1'b1, 12'h324, p);
         settle;
         chk("mc off", {fv, fp}, 0);
      end
      $display("policy test done");
      for (int m = 0; m < 4; m++)
      begin
         hd <= m[1];
         bus(1'b1, 12'h330, {24'h0, m[0], 6'h07, m[0]});
         settle;
         chk("backoff", {alt, aggr}, {2{m[0] & m[1]}});
      end
      $display("back-off test done");
      drop_case(8'h0E, 16'h8808, 16'h0000, 1'b0, 1'b1);
      drop_case(8'h0E, 16'h0800, 16'h0000, 1'b1, 1'b1);
      drop_case(8'h0E, 16'h0800, 16'h0000, 1'b0, 1'b0);
      drop_case(8'h0C, 16'h8808, 16'h0000, 1'b0, 1'b0);
      drop_case(8'h0C, 16'h8808, 16'h0000, 1'b1, 1'b1);
      drop_case(8'h0E, 16'h0040, 16'h0041, 1'b0, 1'b1);
      drop_case(8'h06, 16'h0040, 16'h0041, 1'b0, 1'b0);
      drop_case(8'h0E, 16'h05DC, 16'h0001, 1'b0, 1'b0);
      drop_case(8'h0E, 16'h05DB, 16'h0001, 1'b0, 1'b1);
      $display("drop test done");
      stop_test;
   end
endmodule
